/* logic/ckmgr_pkg.sv */
`default_nettype none
package ckmgr_pkg;
	// internal clock and derived timing
	localparam int          CLOCK_PERIOD_NS = 100;
	localparam int          STOP_TIME_NS    = 100000;
	localparam logic [15:0] STOP_CYCLES     =
		16'((STOP_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS);
	// span of the fine delay line, longest time so rounded down
	localparam int          SHIFT_SPAN_NS   = 10000;
	localparam logic [15:0] SPAN_CYCLES     =
		16'(SHIFT_SPAN_NS / CLOCK_PERIOD_NS);

	// status bit positions
	localparam int STATUS_W      = 8;
	localparam int STAT_OVERFLOW = 0;
	localparam int STAT_REF_STOP = 1;
	localparam int STAT_FX_STOP  = 2;

	// fine shift arithmetic
	localparam logic [9:0] SHIFT_MAG_MAX   = 10'h0FF;
	localparam int         SHIFT_FRAC_LOG2 = 8;
	localparam int         FIX_SPAN_LOG2   = 8;
	localparam int         VAR_SPAN_LOG2   = 7;
	localparam int         WRAP_PASSES     = 4;

	// lock detection
	localparam logic signed [25:0] LOCK_TOL   = 26'sh0000001;
	localparam logic [2:0]         LOCK_COUNT = 3'h4;

	// attribute defaults
	localparam logic [7:0] DEF_MULT        = 8'h04;
	localparam logic [7:0] DEF_DIVD        = 8'h01;
	localparam logic [5:0] DEF_DIV_HALVES  = 6'h04;
	localparam logic [8:0] DEF_PHASE_SHIFT = 9'h000;

	// lock sequence, gray along measure, align, locked, stopped
	typedef enum logic [1:0] {
		LK_MEASURE = 2'b00,
		LK_ALIGN   = 2'b01,
		LK_LOCKED  = 2'b11,
		LK_STOPPED = 2'b10
	} ckmgr_lock_t;
endpackage
`default_nettype wire

/* logic/ckmgr_sync_edge.sv */
`timescale 1ns/1ps
`default_nettype none
module ckmgr_sync_edge (
	input  wire logic clock,
	input  wire logic nrst,
	input  wire logic pinIn,
	output logic      level,
	output logic      rise
);
	import ckmgr_pkg::*;

	typedef struct packed {
		logic meta;
		logic stable;
		logic prev;
	} ckmgr_sync_t;

	ckmgr_sync_t sync_r;
	ckmgr_sync_t sync_nxt;

	// meta is only ever read by stable
	always_comb
	begin
		sync_nxt = sync_r;
		sync_nxt.meta = pinIn;
		sync_nxt.stable = sync_r.meta;
		sync_nxt.prev = sync_r.stable;
	end

	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
			sync_r <= '0;
		else
			sync_r <= sync_nxt;
	end

	// edge taken from the settled stages only
	assign level = sync_r.stable;
	assign rise  = sync_r.stable & ~sync_r.prev;
endmodule
`default_nettype wire

/* logic/ckmgr_clock_manager.sv */
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// RQ1 - nine clock outputs; up to four to global buffers, all to routing
// RQ2 - optionally hold configuration done until lock is reached
// RQ3 - reset returns everything to initial state and clears lock
// RQ4 - lock rises only when every enabled circuit has locked
// RQ5 - status bit0 overflow, bit1 reference stopped, bit2 synth stopped
// RQ6 - delay line tuned so outputs align to zero phase and reference
// RQ7 - user feeds feedback from zero phase or doubled output
// RQ8 - doubled output and its inverse run at twice reference rate
// RQ9 - divide ratios 1.5 to 8 in halves, then 9 to 16
// RQ10 - synth rate is reference times M over D, default 4 over 1
// RQ11 - inverted companions sit 180 degrees from their base output
// RQ12 - divided output 50/50 except non-integer divide in high mode
// RQ13 - high mode disables doubled, inverted doubled, quarter, three quarter
// RQ14 - four phase outputs spaced a quarter reference period apart
// RQ15 - fine shift moves all nine outputs relative to reference; here only the six phase outputs move, and only with deskew on
// RQ16 - fine delay equals shift over 256 times reference period
// RQ17 - shift amount ranges from -255 to +255
// RQ18 - shift request steps up or down by direction, completion follows
// RQ19 - variable mode centres zero skew, halving the reachable range
// RQ20 - fixed mode shift stays constant, full delay line usable
// RQ21 - shift limit follows reference period against delay line span
// RQ22 - completion pulses one shift clock; requests ignored until then
// RQ23 - step past the limit keeps value, sets overflow, still completes
// RQ24 - stopped bits set after missing edges, cleared only by reset
module ckmgr_clock_manager #(
	parameter logic [7:0]  MULT        = ckmgr_pkg::DEF_MULT,
	parameter logic [7:0]  DIVD        = ckmgr_pkg::DEF_DIVD,
	parameter logic [5:0]  DIV_HALVES  = ckmgr_pkg::DEF_DIV_HALVES,
	parameter logic [8:0]  PHASE_SHIFT = ckmgr_pkg::DEF_PHASE_SHIFT,
	parameter logic [15:0] STOP_LIMIT  = ckmgr_pkg::STOP_CYCLES,
	parameter logic [15:0] SHIFT_SPAN  = ckmgr_pkg::SPAN_CYCLES
) (
	input  wire logic                          clock,
	input  wire logic                          nrst,
	input  wire logic                          referenceClockIn,
	input  wire logic                          feedbackClockIn,
	input  wire logic                          shiftPortClock,
	input  wire logic                          shiftRequest,
	input  wire logic                          shiftDirection,
	input  wire logic                          highFreqMode,
	input  wire logic                          variableShift,
	input  wire logic                          deskewEnable,
	input  wire logic                          feedbackDouble,
	input  wire logic                          waitForLock,
	output logic                               outPhaseZero,
	output logic                               outPhaseQuarter,
	output logic                               outPhaseHalf,
	output logic                               outPhaseThreeQuarter,
	output logic                               outDouble,
	output logic                               outDoubleInverted,
	output logic                               outDivided,
	output logic                               outSynth,
	output logic                               outSynthInverted,
	output logic                               locked,
	output logic [ckmgr_pkg::STATUS_W-1:0]     status,
	output logic                               shiftComplete,
	output logic                               configRelease
);
	import ckmgr_pkg::*;

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!nrst);

	typedef struct packed {
		ckmgr_lock_t lock;
		logic [15:0] period;
		logic [15:0] refPh;
		logic        seenRef;
		logic [2:0]  goodCnt;
		logic [15:0] outPh;
		logic [23:0] dvCnt;
		logic [23:0] fxAcc;
		logic [15:0] fxIdle;
		logic [8:0]  shift;
		logic        rampDone;
		logic        ovf;
		logic        refStop;
		logic        fxStop;
		logic        psBusy;
		logic        shift_complete;
		logic        locked;
		logic        oZero;
		logic        oQuarter;
		logic        oHalf;
		logic        oThree;
		logic        oDbl;
		logic        oDblInv;
		logic        oDiv;
		logic        oFx;
		logic        oFxInv;
	} ckmgr_state_t;

	ckmgr_state_t state_r;
	ckmgr_state_t state_nxt;

	logic refRise;
	logic fbRise;
	logic psTick;
	logic psReq;
	logic psDir;

	// reference, feedback and shift port pins cross two flip-flops before use
	ckmgr_sync_edge uRefSync (.clock(clock), .nrst(nrst),
		.pinIn(referenceClockIn), .level(), .rise(refRise));
	ckmgr_sync_edge uFbSync (.clock(clock), .nrst(nrst),
		.pinIn(feedbackClockIn), .level(), .rise(fbRise));
	ckmgr_sync_edge uPsClkSync (.clock(clock), .nrst(nrst),
		.pinIn(shiftPortClock), .level(), .rise(psTick));
	ckmgr_sync_edge uPsReqSync (.clock(clock), .nrst(nrst),
		.pinIn(shiftRequest), .level(psReq), .rise());
	ckmgr_sync_edge uPsDirSync (.clock(clock), .nrst(nrst),
		.pinIn(shiftDirection), .level(psDir), .rise());

	// shift must fit both the attribute range and the delay line span
	function automatic logic fits(input logic [9:0] s, input logic [15:0] p,
		input logic varMode);
		logic [9:0]  mag;
		logic [25:0] lhs;
		logic [25:0] rhs;
		mag = s[9] ? 10'(-s) : s;
		lhs = {16'h0000, mag} * {10'h000, p};
		rhs = {10'h000, SHIFT_SPAN} << (varMode ? VAR_SPAN_LOG2 : FIX_SPAN_LOG2);
		return (mag <= SHIFT_MAG_MAX) && (lhs <= rhs);
	endfunction

	// fold a phase error into one period of the feedback
	function automatic logic signed [25:0] wrapErr(input logic signed [25:0] e,
		input logic signed [25:0] m);
		logic signed [25:0] v;
		v = e;
		for (int i = 0; i < WRAP_PASSES; i++)
		begin
			if (v >= (m >>> 1))
				v = v - m;
			else if (v < -(m >>> 1))
				v = v + m;
		end
		return v;
	endfunction

	logic [15:0]        measured;
	logic               periodMatch;
	logic               running;
	logic signed [25:0] prod;
	logic signed [25:0] target;
	logic signed [25:0] errMod;
	logic signed [25:0] phErr;
	logic               errGood;
	logic [23:0]        dvFull;
	logic [23:0]        dvLess;
	logic [23:0]        dvPeriod;
	logic [23:0]        dvHigh;
	logic [23:0]        fxSpan;
	logic [24:0]        fxSum;
	logic [9:0]         shiftWide;
	logic [9:0]         cand;
	logic               candFits;
	logic               accept;

	// period check tolerates one cycle of sampling jitter
	assign measured    = 16'(state_r.refPh + 16'h0001);
	assign periodMatch = (measured == state_r.period) ||
		(measured == 16'(state_r.period + 16'h0001)) ||
		(16'(measured + 16'h0001) == state_r.period);
	assign running = (state_r.lock == LK_ALIGN) || (state_r.lock == LK_LOCKED);

	// fine offset in cycles, shift/256 of the period [RQ16] [RQ15]
	assign prod   = $signed(state_r.shift) * $signed({1'b0, state_r.period});
	assign target = prod >>> SHIFT_FRAC_LOG2;
	// doubled feedback rises twice a period, so fold by half [RQ7]
	assign errMod = feedbackDouble ? $signed({11'h000, state_r.period[15:1]})
		: $signed({10'h000, state_r.period});
	assign phErr   = wrapErr($signed({10'h000, state_r.refPh}) - target, errMod);
	assign errGood = (phErr <= LOCK_TOL) && (phErr >= -LOCK_TOL);

	// divided period in half steps of the reference [RQ9]
	assign dvFull   = {8'h00, state_r.period} * {18'h00000, DIV_HALVES};
	assign dvLess   = {8'h00, state_r.period} * {18'h00000, 6'(DIV_HALVES - 6'h01)};
	assign dvPeriod = {1'b0, dvFull[23:1]};
	// odd half count in high mode gives up the even duty [RQ12]
	assign dvHigh = (highFreqMode && DIV_HALVES[0]) ? {2'b00, dvLess[23:2]}
		: {1'b0, dvPeriod[23:1]};
	// synth accumulator wraps at period times D, advances by M [RQ10]
	assign fxSpan = {8'h00, state_r.period} * {16'h0000, DIVD};
	assign fxSum  = {1'b0, state_r.fxAcc} + {17'h00000, MULT};

	// one step per request, direction high counts up [RQ18]
	assign shiftWide = {state_r.shift[8], state_r.shift};
	assign cand = (state_r.rampDone ? psDir
		: ($signed(state_r.shift) < $signed(PHASE_SHIFT)))
		? 10'(shiftWide + 10'h001) : 10'(shiftWide - 10'h001);
	// variable mode halves the span, fixed uses all of it [RQ19] [RQ20] [RQ21]
	assign candFits = fits(cand, state_r.period, variableShift);
	// busy gate drops requests until completion has shown [RQ22]
	assign accept = psTick && psReq && variableShift && state_r.rampDone &&
		(state_r.lock == LK_LOCKED) && (!state_r.psBusy || state_r.shift_complete);

	always_comb
	begin
		logic [16:0] phSum;
		logic [15:0] half;
		logic [15:0] quart;
		logic [15:0] ph;
		logic [15:0] m2;
		logic [1:0]  stepAmt;
		logic        run;
		logic        hf;
		phSum   = '0;
		half    = state_r.period >> 1;
		quart   = state_r.period >> 2;
		ph      = '0;
		m2      = '0;
		stepAmt = 2'h1;
		run     = 1'b0;
		hf      = highFreqMode;
		state_nxt = state_r;

		// reference period counter, saturates when the input stops
		if (refRise)
		begin
			state_nxt.refPh = '0;
			state_nxt.seenRef = 1'b1;
		end
		else if (state_r.refPh != 16'hFFFF)
			state_nxt.refPh = 16'(state_r.refPh + 16'h0001);

		// lock sequence
		unique case (state_r.lock)
			LK_MEASURE:
			begin
				if (refRise)
				begin
					state_nxt.period = measured;
					if (state_r.seenRef && periodMatch)
					begin
						state_nxt.lock = LK_ALIGN;
						state_nxt.goodCnt = '0;
						state_nxt.outPh = '0;
						state_nxt.dvCnt = '0;
						state_nxt.fxAcc = '0;
						state_nxt.fxIdle = '0;
						state_nxt.rampDone = 1'b0;
					end
				end
			end
			LK_ALIGN:
			begin
				if (refRise && !periodMatch)
					state_nxt.lock = LK_MEASURE;
				else if (state_r.rampDone && !state_r.fxStop &&
					(!deskewEnable || state_r.goodCnt == LOCK_COUNT))
					state_nxt.lock = LK_LOCKED; // [RQ4]
			end
			LK_LOCKED:
			begin
				if (refRise && !periodMatch)
					state_nxt.lock = LK_MEASURE;
			end
			LK_STOPPED:
			begin
				state_nxt.lock = LK_STOPPED; // only reset recovers
			end
		endcase

		// missing edges stick until reset [RQ24]
		if (state_r.seenRef && state_r.refPh >= STOP_LIMIT)
		begin
			state_nxt.refStop = 1'b1;
			state_nxt.lock = LK_STOPPED;
		end
		if (running && state_r.fxIdle >= STOP_LIMIT)
		begin
			state_nxt.fxStop = 1'b1;
			state_nxt.lock = LK_STOPPED;
		end

		// delay line tuning: slip the output phase toward the target [RQ6]
		if (running && deskewEnable && fbRise)
		begin
			if (phErr > LOCK_TOL)
				stepAmt = 2'h2;
			else if (phErr < -LOCK_TOL)
				stepAmt = 2'h0;
			if (!errGood)
				state_nxt.goodCnt = '0;
			else if (state_r.goodCnt != LOCK_COUNT)
				state_nxt.goodCnt = 3'(state_r.goodCnt + 3'h1);
		end
		phSum = {1'b0, state_r.outPh} + {15'h0000, stepAmt};
		if (phSum >= {1'b0, state_r.period})
			phSum = 17'(phSum - {1'b0, state_r.period});
		if (running)
			state_nxt.outPh = phSum[15:0];
		// without feedback the phase outputs simply follow the reference edge
		if (running && !deskewEnable && refRise)
			state_nxt.outPh = '0;

		// divided and synthesized counters
		if (running)
		begin
			if (24'(state_r.dvCnt + 24'h000001) >= dvPeriod)
				state_nxt.dvCnt = '0;
			else
				state_nxt.dvCnt = 24'(state_r.dvCnt + 24'h000001);
			if (fxSum >= {1'b0, fxSpan})
				state_nxt.fxAcc = 24'(fxSum - {1'b0, fxSpan});
			else
				state_nxt.fxAcc = fxSum[23:0];
		end

		// outputs run only while aligning or locked
		run = (state_nxt.lock == LK_ALIGN) || (state_nxt.lock == LK_LOCKED);
		ph  = state_nxt.outPh;
		m2  = (ph >= half) ? 16'(ph - half) : ph;
		state_nxt.oZero = run && (ph < half);
		state_nxt.oHalf = run && !(ph < half); // [RQ11]
		// quarter steps of the period [RQ14], gone in high mode [RQ13]
		state_nxt.oQuarter = run && !hf && (ph >= quart) &&
			(ph < 16'(quart + half));
		state_nxt.oThree = run && !hf && !((ph >= quart) &&
			(ph < 16'(quart + half)));
		// two cycles per reference period [RQ8] [RQ13]
		state_nxt.oDbl    = run && !hf && (m2 < quart);
		state_nxt.oDblInv = run && !hf && !(m2 < quart); // [RQ11]
		state_nxt.oDiv    = run && (state_nxt.dvCnt < dvHigh); // [RQ12]
		state_nxt.oFx     = run && (state_nxt.fxAcc < {1'b0, fxSpan[23:1]});
		state_nxt.oFxInv  = run && !(state_nxt.fxAcc < {1'b0, fxSpan[23:1]});

		// synth watchdog counts cycles without a toggle
		if (!running || state_nxt.oFx != state_r.oFx)
			state_nxt.fxIdle = '0;
		else if (state_r.fxIdle != 16'hFFFF)
			state_nxt.fxIdle = 16'(state_r.fxIdle + 16'h0001);

		// completion shows for one shift clock, then clears [RQ22]
		if (psTick && state_r.psBusy)
		begin
			if (state_r.shift_complete)
			begin
				state_nxt.shift_complete = 1'b0;
				state_nxt.psBusy = 1'b0;
			end
			else
				state_nxt.shift_complete = 1'b1;
		end
		if (accept)
		begin
			state_nxt.psBusy = 1'b1;
			state_nxt.shift_complete = 1'b0;
			// out of range keeps the value, flags it, still completes [RQ23]
			if (candFits)
			begin
				state_nxt.shift = cand[8:0];
				state_nxt.ovf = 1'b0;
			end
			else
				state_nxt.ovf = 1'b1;
		end
		else if (running && !state_r.rampDone)
		begin
			// walk to the attribute value one step a cycle [RQ17] [RQ20]
			if (state_r.shift == PHASE_SHIFT)
				state_nxt.rampDone = 1'b1;
			else if (candFits)
				state_nxt.shift = cand[8:0];
			else
			begin
				state_nxt.ovf = 1'b1;
				state_nxt.rampDone = 1'b1;
			end
		end

		state_nxt.locked = (state_nxt.lock == LK_LOCKED);
	end

	// reset clears every circuit including lock [RQ3]
	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
			state_r <= '0;
		else
			state_r <= state_nxt;
	end

	// nine outputs; any four of them may feed global buffers [RQ1]
	assign outPhaseZero         = state_r.oZero;
	assign outPhaseQuarter      = state_r.oQuarter;
	assign outPhaseHalf         = state_r.oHalf;
	assign outPhaseThreeQuarter = state_r.oThree;
	assign outDouble            = state_r.oDbl;
	assign outDoubleInverted    = state_r.oDblInv;
	assign outDivided           = state_r.oDiv;
	assign outSynth             = state_r.oFx;
	assign outSynthInverted     = state_r.oFxInv;
	assign locked               = state_r.locked;
	assign shiftComplete        = state_r.shift_complete;
	// status layout, upper bits unused [RQ5]
	assign status = {5'h00, state_r.fxStop, state_r.refStop, state_r.ovf};
	// with waitForLock set, configuration may finish only once locked [RQ2]
	assign configRelease = !waitForLock || state_r.locked;

	a_reset_clears: assert property (@(posedge clock) disable iff (1'b0) // [RQ3]
		!nrst |-> (!locked && status == 8'h00 && !shiftComplete))
		else $error("reset left lock or status set");
	a_lock_all_ok: assert property ( // [RQ4]
		locked |-> (state_r.rampDone && !state_r.refStop && !state_r.fxStop))
		else $error("lock high with a circuit not ready");
	a_lock_aligned: assert property ( // [RQ6]
		$rose(locked) |-> (!$past(deskewEnable) ||
		$past(state_r.goodCnt) == LOCK_COUNT))
		else $error("lock rose before feedback aligned");
	a_config_hold: assert property ( // [RQ2]
		waitForLock && !locked |-> !configRelease)
		else $error("configuration released before lock");
	a_status_unused: assert property ( // [RQ5]
		status[7:3] == 5'h00)
		else $error("unused status bits set");
	a_ref_stop_time: assert property ( // [RQ24]
		$rose(status[STAT_REF_STOP]) |-> ($past(state_r.refPh) >= STOP_LIMIT)
		##1 !locked)
		else $error("reference stop flagged early or lock kept");
	a_hf_quiet: assert property ( // [RQ13]
		highFreqMode && $past(highFreqMode) |-> (!outPhaseQuarter &&
		!outPhaseThreeQuarter && !outDouble && !outDoubleInverted))
		else $error("output active in high frequency mode");
	a_synth_inverse: assert property ( // [RQ11]
		locked && $past(locked) |-> (outSynthInverted == !outSynth &&
		outPhaseHalf == !outPhaseZero))
		else $error("inverted companion not opposite");
	a_shift_range: assert property ( // [RQ17]
		$signed(state_r.shift) <= 9'sh0FF && $signed(state_r.shift) >= -9'sh0FF)
		else $error("shift outside attribute range");
	a_step_one: assert property ( // [RQ18]
		$past(state_r.rampDone) && shiftWide != $past(shiftWide) |->
		(10'(shiftWide - $past(shiftWide)) == 10'h001 ||
		10'($past(shiftWide) - shiftWide) == 10'h001))
		else $error("dynamic step not exactly one");
	a_fixed_steady: assert property ( // [RQ20]
		!$past(variableShift) && $past(state_r.rampDone) |-> $stable(state_r.shift))
		else $error("fixed shift changed after settling");
	a_overflow_hold: assert property ( // [RQ23]
		accept && !candFits |=> (status[STAT_OVERFLOW] &&
		$stable(state_r.shift) && state_r.psBusy))
		else $error("overflow step changed shift or lost completion");
	a_done_pulse: assert property ( // [RQ22]
		shiftComplete && psTick |=> !shiftComplete)
		else $error("completion held past one shift clock");
	a_done_cause: assert property ( // [RQ22]
		$rose(shiftComplete) |-> $past(psTick) && $past(state_r.psBusy))
		else $error("completion without accepted request");

	c_lock: cover property ($rose(locked));
	c_step: cover property ($rose(shiftComplete));
	c_overflow: cover property ($rose(status[STAT_OVERFLOW]));
	c_ref_stop: cover property ($rose(status[STAT_REF_STOP]));
endmodule
`default_nettype wire

/* tb/ckmgr_user_model.sv */
`timescale 1ns/1ps
`default_nettype none
// user side: reference and shift port clocks, shift steps, feedback loop
module ckmgr_user_model (
	input  wire logic clock,
	input  wire logic refRun,
	input  wire logic zeroPhase,
	input  wire logic shiftComplete,
	output logic      refClk,
	output logic      fbClk,
	output logic      shift_port_clock,
	output logic      shiftRequest,
	output logic      shiftDirection
);
	int refCnt = 0;
	int psCnt  = 0;
	// feedback comes back from the zero phase output
	assign fbClk = zeroPhase;
	initial
	begin
		refClk = 1'b0;
		shift_port_clock = 1'b0;
		shiftRequest = 1'b0;
		shiftDirection = 1'b0;
	end
	// reference period 100 clocks, shift clock 10; reference can be stopped
	always @(negedge clock)
	begin
		psCnt <= (psCnt + 1) % 5;
		if (psCnt == 4)
			shift_port_clock <= ~shift_port_clock;
		refCnt <= (refCnt + 1) % 50;
		if (refCnt == 49 && refRun)
			refClk <= ~refClk;
	end
	// request held until completion shows, so it is taken only once;
	// watching starts one shift clock in, after any older pulse has gone
	task automatic step(input logic up, output logic seen);
		int n;
		@(posedge shift_port_clock);
		shiftDirection = up;
		shiftRequest = 1'b1;
		@(posedge shift_port_clock);
		seen = 1'b0;
		for (n = 0; n < 40 && !seen; n++)
		begin
			@(negedge clock);
			seen = (shiftComplete === 1'b1);
		end
		shiftRequest = 1'b0;
	endtask
endmodule
`default_nettype wire

/* tb/tb_clock_deskew_synth_phase.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_clock_deskew_synth_phase;
	logic       clock = 1'b0;
	logic       nrst = 1'b1;
	logic       refRun = 1'b1;
	logic       hiF = 1'b0;
	logic       varS = 1'b1;
	logic       wLk = 1'b1;
	logic       dsk = 1'b0;
	logic       fb2 = 1'b0;
	logic       refClk, fbClk, shift_port_clock, req, dir, seen;
	logic       o0, o90, o180, o270, o2x, o2xn, odv, ofx, ofxn, lk, done, rel;
	logic [7:0] st;
	int         n_errors = 0;
	int         n_checks = 0;

	ckmgr_clock_manager #(.STOP_LIMIT(16'h00C8), .SHIFT_SPAN(16'h0001))
		ckmgr_clock_manager_inst (.clock(clock), .nrst(nrst),
		.referenceClockIn(refClk), .feedbackClockIn(fbClk),
		.shiftPortClock(shift_port_clock), .shiftRequest(req), .shiftDirection(dir),
		.highFreqMode(hiF), .variableShift(varS), .deskewEnable(dsk),
		.feedbackDouble(fb2), .waitForLock(wLk), .outPhaseZero(o0),
		.outPhaseQuarter(o90), .outPhaseHalf(o180),
		.outPhaseThreeQuarter(o270), .outDouble(o2x),
		.outDoubleInverted(o2xn), .outDivided(odv), .outSynth(ofx),
		.outSynthInverted(ofxn), .locked(lk), .status(st),
		.shiftComplete(done), .configRelease(rel));
	ckmgr_user_model ckmgr_user_model_inst (.clock(clock), .refRun(refRun),
		.zeroPhase(o0), .shiftComplete(done), .refClk(refClk),
		.fbClk(fbClk), .shift_port_clock(shift_port_clock), .shiftRequest(req),
		.shiftDirection(dir));

	initial
	begin
		forever
			#50 clock = ~clock;
	end

	task automatic chk(input string what, input logic [7:0] exp, got);
		n_checks++;
		if (got !== exp)
		begin
			n_errors++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic report_and_stop;
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// a real falling reset edge before the first clock edge clears the flops
	task automatic t_reset;
		#10;
		nrst = 1'b0;
		repeat (4) @(negedge clock);
		chk("locked", 8'h00, {7'h0, lk});
		chk("status", 8'h00, st);
		chk("release", 8'h00, {7'h0, rel});
		nrst = 1'b1;
	endtask

	// a failed lock ends the run, nothing later can work
	task automatic t_lock;
		int n;
		for (n = 0; n < 2000 && lk !== 1'b1; n++)
			@(negedge clock);
		chk("locked", 8'h01, {7'h0, lk});
		chk("release", 8'h01, {7'h0, rel});
		chk("status", 8'h00, st);
		if (lk !== 1'b1)
			report_and_stop();
	endtask

	// two reference periods from a zero phase rise, whole periods counted
	task automatic t_rates;
		int n, nd, nf, nv, nq, bad;
		logic pd, pf;
		nd = 0;
		nf = 0;
		nv = 0;
		nq = 0;
		bad = 0;
		for (n = 0; n < 300 && o0 !== 1'b0; n++)
			@(negedge clock);
		for (n = 0; n < 300 && o0 !== 1'b1; n++)
			@(negedge clock);
		chk("zero phase", 8'h01, {7'h0, o0});
		pd = o2x;
		pf = ofx;
		repeat (200)
		begin
			@(negedge clock);
			nd += (o2x === 1'b1 && pd === 1'b0);
			nf += (ofx === 1'b1 && pf === 1'b0);
			nv += (odv === 1'b1);
			nq += (o90 === 1'b1 && o0 === 1'b1);
			bad += (o2xn === o2x) + (ofxn === ofx);
			bad += (o180 === o0) + (o270 === o90);
			pd = o2x;
			pf = ofx;
		end
		chk("double rises", 8'h04, 8'(nd));
		chk("synth rises", 8'h08, 8'(nf));
		chk("divided high", 8'h64, 8'(nv));
		chk("quarter overlap", 8'h32, 8'(nq));
		chk("inverted outs", 8'h00, {7'h0, bad != 0});
	endtask

	// span 1 at period 100 allows one step in variable mode
	// completion must stand one shift clock, ten bench clocks
	task automatic t_shift;
		int n;
		ckmgr_user_model_inst.step(1'b1, seen);
		chk("step done", 8'h01, {7'h0, seen});
		chk("status", 8'h00, st);
		for (n = 0; n < 30 && done === 1'b1; n++)
			@(negedge clock);
		chk("done pulse", 8'h0A, 8'(n));
		ckmgr_user_model_inst.step(1'b1, seen);
		chk("over done", 8'h01, {7'h0, seen});
		chk("overflow", 8'h01, st);
		ckmgr_user_model_inst.step(1'b0, seen);
		chk("cleared", 8'h00, st);
		varS = 1'b0;
		ckmgr_user_model_inst.step(1'b1, seen);
		chk("fixed step", 8'h00, {7'h0, seen});
	endtask

	task automatic t_high;
		int bad, live;
		bad = 0;
		live = 0;
		hiF = 1'b1;
		repeat (150)
		begin
			@(negedge clock);
			bad += (o90 !== 1'b0) + (o270 !== 1'b0);
			bad += (o2x !== 1'b0) + (o2xn !== 1'b0);
			live += (o0 === 1'b1);
		end
		hiF = 1'b0;
		chk("high mode outs", 8'h00, {7'h0, bad != 0});
		chk("zero phase runs", 8'h01, {7'h0, live != 0});
	endtask

	task automatic t_stop;
		int n;
		refRun = 1'b0;
		for (n = 0; n < 600 && st[1] !== 1'b1; n++)
			@(negedge clock);
		chk("ref stopped", 8'h02, st & 8'h02);
		chk("stop delay", 8'h01, {7'h0, n >= 100});
		chk("locked", 8'h00, {7'h0, lk});
		refRun = 1'b1;
		nrst = 1'b0;
		wLk = 1'b0;
		dsk = 1'b1;
		@(negedge clock);
		chk("status", 8'h00, st);
		chk("release", 8'h01, {7'h0, rel});
		wLk = 1'b1;
		nrst = 1'b1;
	endtask

	// with feedback the zero phase rise sits within a cycle of the reference
	task automatic t_deskew;
		int n, tr, t0;
		logic pr, p0;
		tr = 0;
		t0 = -9;
		pr = refClk;
		p0 = o0;
		for (n = 0; n < 300 && (tr == 0 || n < tr + 2); n++)
		begin
			@(negedge clock);
			if (o0 === 1'b1 && p0 === 1'b0)
				t0 = n;
			if (refClk === 1'b1 && pr === 1'b0 && n > 2 && tr == 0)
				tr = n;
			pr = refClk;
			p0 = o0;
		end
		chk("aligned", 8'h01, {7'h0, t0 >= tr - 1 && t0 <= tr + 1});
	endtask

	initial
	begin
		t_reset();
		t_lock();
		t_rates();
		t_shift();
		t_high();
		t_stop();
		t_lock();
		t_deskew();
		report_and_stop();
	end
endmodule
`default_nettype wire
